// >>> inc/msa_pkg.sv
// Shared constants and types of the memory scan access arbiter.
// Assumes one instruction clock and a word-wide program memory read port.
package msa_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int TSEL_W = 4;
	localparam int NTRIG = 16;
	localparam int BUF_DEPTH = 2;

	// ****************************************************************
	// Mode field encodings
	// ****************************************************************
	localparam logic [1:0] MODE_CONCURRENT = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_PEEK = 2'h2;
	localparam logic [1:0] MODE_TRIGGERED = 2'h3;

	// ****************************************************************
	// Address space and reset values
	// ****************************************************************
	// Highest implemented word address; plain default
	localparam logic [ADDR_W-1:0] LAST_IMPL_ADDR = 22'h00FFFF;
	// Memory is word addressed, one CRC word per step
	localparam logic [ADDR_W-1:0] ADDR_STEP = 22'h000001;
	localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
	localparam logic FLAG_RST = 1'h0;

	// ****************************************************************
	// Scanner states
	// ****************************************************************
	typedef enum logic [1:0] {
		MSA_IDLE,
		MSA_WAIT_TRIG,
		MSA_RUN
	} msa_state_e;

endpackage

// >>> rtl/msa_buf.sv
// Two-entry buffer between program memory reads and the CRC input.
// Assumes the filler honours o_in_ready; outputs come from flip-flops.
`timescale 1ns/1ps
module msa_buf (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [msa_pkg::DATA_W-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [msa_pkg::DATA_W-1:0] o_out_data,
	input wire logic i_out_ready,
	output logic [1:0] o_count
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [msa_pkg::DATA_W-1:0] mem_r [msa_pkg::BUF_DEPTH];
	logic [msa_pkg::BUF_DEPTH-1:0] vld_r;
	logic [msa_pkg::BUF_DEPTH-1:0] vld_nxt;
	logic [msa_pkg::DATA_W-1:0] d0_nxt;
	logic [msa_pkg::DATA_W-1:0] d1_nxt;
	wire push = i_in_valid && o_in_ready;
	wire pop = vld_r[0] && i_out_ready;

	assign o_in_ready = !vld_r[1];
	assign o_out_valid = vld_r[0];
	assign o_out_data = mem_r[0];
	assign o_count = {1'b0, vld_r[0]} + {1'b0, vld_r[1]};

	// Entry 0 is always the head, so the output is a plain register
	always_comb begin
		vld_nxt = vld_r;
		d0_nxt = mem_r[0];
		d1_nxt = mem_r[1];
		if (pop) begin
			d0_nxt = mem_r[1];
			vld_nxt = {1'b0, vld_r[1]};
		end
		if (push) begin
			if (vld_nxt[0]) begin
				d1_nxt = i_in_data;
				vld_nxt[1] = 1'b1;
			end else begin
				d0_nxt = i_in_data;
				vld_nxt[0] = 1'b1;
			end
		end
		if (i_flush) begin
			vld_nxt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			vld_r <= '0;
		end else begin
			vld_r <= vld_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		mem_r[0] <= d0_nxt;
		mem_r[1] <= d1_nxt;
	end

endmodule

// >>> rtl/msa_arbiter.sv
// Memory scan access arbiter: shares program memory reads between the
// CPU and the scanner feeding the CRC engine.
// Assumes synchronous inputs; i_cpu_fetch_nxt tells one cycle ahead
// whether the CPU needs program memory; read data is valid while
// o_mem_rd is high.
//
// How it works
// - Burst mode stalls the CPU from the cycle after scan start until stop.
// - Burst reads run every instruction clock while room remains.
// - Software clear is ignored in burst; only hardware ends the scan.
// - Concurrent mode stalls the CPU only in cycles with a scan read.
// - Triggered mode waits for a rising trigger edge, then acts concurrent.
// - Peek reads only in CPU-free cycles; interrupt priority is ignored.
// - The first peek read takes the first dead cycle after start.
// - Burst with priority set: interrupt hides scan_run and pauses burst.
// - Burst with priority clear: interrupts do not touch the burst.
// - Concurrent/triggered with priority set: suspend while interrupt runs.
// - Concurrent/triggered, priority clear: reads go on during interrupt.
// - Watchdog is never held by scanning; only the CPU is stalled.
// - Debug halt freezes the scanner; state and address stay visible.
// - Halt during the start instruction delays the burst until exit.
// - Halt during a burst suspends it; it resumes on exit.
// - Halt before a scan cycle defers that read until exit.
// - Halt during a scan cycle lets the granted read finish.
// - A peek slot lost to debug entry is taken after exit.
// - Breakpoint on the start instruction starts the burst after exit.
// - Scan stops at end or unimplemented address, clears run, flags done.
// - Losing an enable or CRC start mid-scan aborts and flags invalid.
`timescale 1ns/1ps
module msa_arbiter (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scan_enable,
	input wire logic i_crc_enable,
	input wire logic i_crc_go,
	input wire logic [1:0] i_mode,
	input wire logic i_irq_priority_select,
	input wire logic [msa_pkg::TSEL_W-1:0] i_scan_trigger_select,
	input wire logic [msa_pkg::NTRIG-1:0] i_triggers,
	input wire logic i_scan_run_set,
	input wire logic i_scan_run_clr,
	input wire logic [msa_pkg::ADDR_W-1:0] i_start_addr,
	input wire logic [msa_pkg::ADDR_W-1:0] i_end_addr,
	input wire logic i_done_clr,
	input wire logic i_cpu_fetch_nxt,
	input wire logic i_irq_active,
	input wire logic i_dbg_halt,
	input wire logic [msa_pkg::DATA_W-1:0] i_mem_data,
	input wire logic i_crc_ready,
	output logic o_mem_rd,
	output logic [msa_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_cpu_stall,
	output logic o_scan_run,
	output logic o_busy,
	output logic o_invalid,
	output logic o_done,
	output logic [msa_pkg::ADDR_W-1:0] o_scan_low_address,
	output logic o_crc_valid,
	output logic [msa_pkg::DATA_W-1:0] o_crc_data
);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	// Interrupt takes precedence only with priority set, never in peek
	function automatic logic irq_wins(input logic [1:0] mode,
		input logic prio, input logic irq);
		irq_wins = irq && prio && (mode != msa_pkg::MODE_PEEK);
	endfunction

	function automatic logic past_end(input logic [msa_pkg::ADDR_W-1:0] a,
		input logic [msa_pkg::ADDR_W-1:0] e);
		past_end = (a > e) || (a > msa_pkg::LAST_IMPL_ADDR);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	msa_pkg::msa_state_e state_r;
	msa_pkg::msa_state_e state_nxt;
	logic [msa_pkg::ADDR_W-1:0] addr_r;
	logic [msa_pkg::ADDR_W-1:0] addr_nxt;
	logic rd_r;
	logic stall_r;
	logic run_vis_r;
	logic busy_r;
	logic invalid_r;
	logic invalid_nxt;
	logic done_r;
	logic done_nxt;
	logic trig_prev_r;
	logic [msa_pkg::ADDR_W-1:0] mem_addr_r;

	wire buf_in_ready;
	wire [1:0] buf_count;
	wire buf_out_valid;
	wire [msa_pkg::DATA_W-1:0] buf_out_data;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire is_burst = (i_mode == msa_pkg::MODE_BURST);
	wire is_peek = (i_mode == msa_pkg::MODE_PEEK);
	wire is_trig = (i_mode == msa_pkg::MODE_TRIGGERED);
	wire enables_ok = i_scan_enable && i_crc_enable && i_crc_go;
	wire active = (state_r != msa_pkg::MSA_IDLE);
	wire irq_pause = irq_wins(i_mode, i_irq_priority_select,
		i_irq_active);
	// Priority clear leaves interrupts out of the decision entirely
	wire hold = i_dbg_halt || irq_pause;

	// Trigger source selection and rising edge
	wire trig_sel = i_triggers[i_scan_trigger_select];
	wire trig_rise = trig_sel && !trig_prev_r;

	// A read in flight still needs a slot, so count it as used
	wire [2:0] used = {1'b0, buf_count} + {2'b00, rd_r};
	wire credit_ok = (used < 3'(msa_pkg::BUF_DEPTH));

	// Peek only takes a cycle the CPU leaves free
	wire slot_ok = is_peek ? !i_cpu_fetch_nxt : 1'b1;

	wire abort = active && !enables_ok;
	wire at_limit = past_end(addr_r, i_end_addr);
	wire run_ok = (state_r == msa_pkg::MSA_RUN) && !abort;
	// Unimplemented or passed end address ends without a read
	// A halted scanner neither reads nor ends
	wire stop_now = run_ok && at_limit && !i_dbg_halt;
	// A halted cycle issues nothing, so a deferred slot is retried later
	wire issue = run_ok && !at_limit && !hold && credit_ok
		&& slot_ok;
	wire last_read = issue && (addr_r == i_end_addr);
	// Burst cannot be cleared by software: CPU is stalled anyway
	wire sw_clr = i_scan_run_clr && !is_burst && !i_scan_run_set;
	// A start with enables missing is refused and flagged
	wire start = i_scan_run_set && !active;
	wire start_bad = start && !enables_ok;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		case (state_r)
			msa_pkg::MSA_IDLE: begin
				if (start && enables_ok) begin
					addr_nxt = i_start_addr;
					// Start is taken even under breakpoint; hold keeps reads off until exit
					state_nxt = is_trig ? msa_pkg::MSA_WAIT_TRIG
						: msa_pkg::MSA_RUN;
				end
			end
			msa_pkg::MSA_WAIT_TRIG: begin
				if (abort || sw_clr) begin
					state_nxt = msa_pkg::MSA_IDLE;
				end else if (trig_rise && !i_dbg_halt) begin
					state_nxt = msa_pkg::MSA_RUN;
				end
			end
			msa_pkg::MSA_RUN: begin
				if (abort || sw_clr || stop_now || last_read) begin
					state_nxt = msa_pkg::MSA_IDLE;
				end
				// Address only moves on a granted read
				if (issue) begin
					addr_nxt = addr_r + msa_pkg::ADDR_STEP;
				end
			end
			default: begin
				state_nxt = msa_pkg::MSA_IDLE;
			end
		endcase
	end

	// Set wins over clear for both sticky flags
	always_comb begin
		done_nxt = done_r;
		invalid_nxt = invalid_r;
		if (i_done_clr) begin
			done_nxt = 1'b0;
		end
		if (stop_now || last_read) begin
			done_nxt = 1'b1;
		end
		if (start && enables_ok) begin
			invalid_nxt = 1'b0;
		end
		if (abort || start_bad) begin
			invalid_nxt = 1'b1;
		end
	end

	// Burst stall drops for a winning interrupt or a debug halt; it
	// reaches the CPU alone, the watchdog keeps counting
	wire burst_stall = is_burst && (state_nxt == msa_pkg::MSA_RUN)
		&& !hold;
	wire stall_nxt = burst_stall || (issue && !is_peek);
	// scan_run reads zero while an interrupt has precedence
	wire run_vis_nxt = (state_nxt != msa_pkg::MSA_IDLE)
		&& !irq_pause;
	wire busy_nxt = (state_nxt != msa_pkg::MSA_IDLE) || issue || rd_r
		|| (buf_count != 2'h0);

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r <= msa_pkg::MSA_IDLE;
			addr_r <= msa_pkg::ADDR_RST;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
		end
	end

	// A granted read always completes, even if a halt arrives next
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rd_r <= msa_pkg::FLAG_RST;
			mem_addr_r <= msa_pkg::ADDR_RST;
		end else begin
			rd_r <= issue;
			mem_addr_r <= issue ? addr_r : mem_addr_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			stall_r <= msa_pkg::FLAG_RST;
			run_vis_r <= msa_pkg::FLAG_RST;
			busy_r <= msa_pkg::FLAG_RST;
		end else begin
			stall_r <= stall_nxt;
			run_vis_r <= run_vis_nxt;
			busy_r <= busy_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			done_r <= msa_pkg::FLAG_RST;
			invalid_r <= msa_pkg::FLAG_RST;
			trig_prev_r <= msa_pkg::FLAG_RST;
		end else begin
			done_r <= done_nxt;
			invalid_r <= invalid_nxt;
			trig_prev_r <= trig_sel;
		end
	end

	// ****************************************************************
	// Buffer toward the CRC
	// ****************************************************************
	// Disable resets the scanner path, so queued words are dropped
	msa_buf msa_buf_i (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flush(abort),
		.i_in_valid(rd_r),
		.i_in_data(i_mem_data),
		.o_in_ready(buf_in_ready),
		.o_out_valid(buf_out_valid),
		.o_out_data(buf_out_data),
		.i_out_ready(i_crc_ready),
		.o_count(buf_count)
	);

	assign o_mem_rd = rd_r;
	assign o_mem_addr = mem_addr_r;
	assign o_cpu_stall = stall_r;
	assign o_scan_run = run_vis_r;
	assign o_busy = busy_r;
	assign o_invalid = invalid_r;
	assign o_done = done_r;
	assign o_scan_low_address = addr_r;
	assign o_crc_valid = buf_out_valid;
	assign o_crc_data = buf_out_data;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_burst_stall_hold: assert property (
		(is_burst && state_r == msa_pkg::MSA_RUN && !hold && !abort
		&& !at_limit && !last_read && !sw_clr) |=> o_cpu_stall)
		else $error("burst run without CPU stall");

	a_conc_stall_read: assert property (
		(i_mode == msa_pkg::MODE_CONCURRENT && !burst_stall && issue)
		|=> (o_cpu_stall && o_mem_rd))
		else $error("concurrent stall not tied to read");

	a_peek_no_stall: assert property (
		(is_peek && $past(is_peek)) |-> !o_cpu_stall)
		else $error("peek stalled the CPU");

	a_peek_dead_slot: assert property (
		(is_peek && $past(is_peek) && o_mem_rd)
		|-> !$past(i_cpu_fetch_nxt))
		else $error("peek read in a CPU fetch cycle");

	a_trig_wait_idle: assert property (
		(state_r == msa_pkg::MSA_WAIT_TRIG) |=> !o_mem_rd)
		else $error("read before trigger edge");

	a_irq_hides_run: assert property (
		(irq_pause && state_nxt != msa_pkg::MSA_IDLE)
		|=> (!o_scan_run && !o_mem_rd))
		else $error("scan ran during priority interrupt");

	a_halt_freeze: assert property (
		(i_dbg_halt && state_r == msa_pkg::MSA_RUN && !abort)
		|=> (!o_mem_rd && $stable(o_scan_low_address)))
		else $error("scanner moved during halt");

	a_end_done: assert property (
		last_read |=> (state_r == msa_pkg::MSA_IDLE && o_done
		&& o_mem_rd ##1 !o_mem_rd))
		else $error("scan did not end at end address");

	a_abort_invalid: assert property (
		abort |=> (o_invalid && !o_scan_run ##1 !o_mem_rd))
		else $error("abort not flagged invalid");

	a_buf_room: assert property (
		rd_r |-> buf_in_ready)
		else $error("read data arrived with buffer full");

	a_burst_irq_run: assert property (
		(is_burst && !i_irq_priority_select && i_irq_active
		&& state_nxt == msa_pkg::MSA_RUN) |=> o_scan_run)
		else $error("interrupt masked a burst without priority");

	a_halt_burst_idle: assert property (
		(is_burst && i_dbg_halt) |=> (!o_cpu_stall && !o_mem_rd))
		else $error("burst went on during halt");

endmodule

// >>> test/msa_partner.sv
// Partner model: program memory read port and CRC word sink.
// Assumes one-cycle read pulses with the address held alongside.
`timescale 1ns/1ps
module msa_partner (
	input wire logic i_clk,
	input wire logic i_mem_rd,
	input wire logic [msa_pkg::ADDR_W-1:0] i_mem_addr,
	output logic [msa_pkg::DATA_W-1:0] o_mem_data,
	input wire logic i_crc_valid,
	input wire logic [msa_pkg::DATA_W-1:0] i_crc_data,
	output logic o_crc_ready,
	input wire logic i_hold
);
	logic [msa_pkg::DATA_W-1:0] last_r;
	logic [msa_pkg::DATA_W-1:0] got[$];
	// Idle data toggles so a stray sample never looks like a real word
	assign o_mem_data = i_mem_rd ? (i_mem_addr[15:0] ^ 16'h5A5A) : ~last_r;
	assign o_crc_ready = !i_hold;
	initial last_r = 16'h0000;
	always @(posedge i_clk) begin
		last_r <= o_mem_data;
		if (i_crc_valid && o_crc_ready)
			got.push_back(i_crc_data);
	end
endmodule

// >>> test/msa_arbiter_test.sv
// Self-checking bench of the memory scan access arbiter.
// Assumes the partner model answers reads and sinks CRC words.
`timescale 1ns/1ps
module msa_arbiter_test;
	logic clk, rst_n, scan_en, crc_en, crc_go, prio, run_set, run_clr;
	logic done_clr, fetch, irq, halt, hold, crc_ready;
	logic mem_rd, stall, scan_run, busy, invalid, done, crc_valid;
	logic [1:0] mode;
	logic [3:0] tsel;
	logic [15:0] trig, mem_data, crc_data;
	logic [21:0] sa, ea, mem_addr, low_addr;
	int bad_count, checks;

	msa_arbiter msa_arbiter_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_scan_enable(scan_en), .i_crc_enable(crc_en), .i_crc_go(crc_go),
		.i_mode(mode), .i_irq_priority_select(prio),
		.i_scan_trigger_select(tsel), .i_triggers(trig),
		.i_scan_run_set(run_set), .i_scan_run_clr(run_clr),
		.i_start_addr(sa), .i_end_addr(ea), .i_done_clr(done_clr),
		.i_cpu_fetch_nxt(fetch), .i_irq_active(irq), .i_dbg_halt(halt),
		.i_mem_data(mem_data), .i_crc_ready(crc_ready), .o_mem_rd(mem_rd),
		.o_mem_addr(mem_addr), .o_cpu_stall(stall), .o_scan_run(scan_run),
		.o_busy(busy), .o_invalid(invalid), .o_done(done),
		.o_scan_low_address(low_addr), .o_crc_valid(crc_valid),
		.o_crc_data(crc_data));

	msa_partner msa_partner_i (.i_clk(clk), .i_mem_rd(mem_rd),
		.i_mem_addr(mem_addr), .o_mem_data(mem_data),
		.i_crc_valid(crc_valid), .i_crc_data(crc_data),
		.o_crc_ready(crc_ready), .i_hold(hold));

	// ****************************************************************
	// Common tasks
	// ****************************************************************
	task automatic finish_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic chk_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Inputs change 5 ns after the edge, so the set pulse is one cycle
	task automatic start(input logic [1:0] m, input logic [21:0] s,
		input logic [21:0] e);
		done_clr = 1'h1;
		mode = m;
		sa = s;
		ea = e;
		msa_partner_i.got.delete();
		step(1);
		done_clr = 1'h0;
		run_set = 1'h1;
		step(1);
		run_set = 1'h0;
	endtask

	// Busy also covers buffered words, so this waits for a full drain
	task automatic wait_idle;
		int i;
		for (i = 0; i < 300 && busy !== 1'h0; i++)
			step(1);
		if (busy !== 1'h0) begin
			bad_count++;
			finish_test();
		end
	endtask

	task automatic chk_words(input logic [21:0] s, input int n);
		logic [21:0] a;
		chk_val(msa_partner_i.got.size(), n);
		for (int i = 0; i < n && i < msa_partner_i.got.size(); i++) begin
			a = s + 22'(i);
			chk_val(msa_partner_i.got[i], a[15:0] ^ 16'h5A5A);
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk_bit(scan_run | stall | mem_rd | busy, 1'h0);
		chk_bit(done | invalid | crc_valid, 1'h0);
		chk_val(low_addr, 22'h000000);
	endtask

	// Receiver stalls first: buffer fills to two, reads stop, none lost
	task automatic t_burst;
		int i;
		hold = 1'h1;
		start(msa_pkg::MODE_BURST, 22'h000010, 22'h000017);
		chk_bit(stall, 1'h1);
		run_clr = 1'h1;
		step(1);
		run_clr = 1'h0;
		step(5);
		chk_bit(scan_run, 1'h1);
		chk_bit(crc_valid, 1'h1);
		chk_val(low_addr, 22'h000012);
		hold = 1'h0;
		for (i = 0; i < 40 && done !== 1'h1; i++) begin
			chk_bit(stall, 1'h1);
			step(1);
		end
		chk_bit(done, 1'h1);
		if (done !== 1'h1)
			finish_test();
		chk_bit(scan_run, 1'h0);
		wait_idle();
		chk_bit(stall, 1'h0);
		chk_words(22'h000010, 8);
	endtask

	task automatic t_conc;
		int i;
		start(msa_pkg::MODE_CONCURRENT, 22'h000040, 22'h000047);
		chk_bit(done, 1'h0);
		for (i = 0; i < 40 && busy !== 1'h0; i++) begin
			chk_bit(stall, mem_rd);
			step(1);
		end
		wait_idle();
		chk_words(22'h000040, 8);
	endtask

	task automatic t_irq(input logic [1:0] m, input logic p);
		int i, n;
		n = 0;
		irq = 1'h1;
		prio = p;
		start(m, 22'h000080, 22'h000087);
		for (i = 0; i < 4; i++) begin
			chk_bit(scan_run, !p);
			if (m == msa_pkg::MODE_BURST)
				chk_bit(stall, !p);
			n += int'(mem_rd);
			step(1);
		end
		chk_bit(n != 0, !p);
		irq = 1'h0;
		wait_idle();
		chk_words(22'h000080, 8);
	endtask

	task automatic t_trig;
		int i, n;
		n = 0;
		tsel = 4'h5;
		start(msa_pkg::MODE_TRIGGERED, 22'h0000C0, 22'h0000C3);
		for (i = 0; i < 6; i++) begin
			chk_bit(mem_rd, 1'h0);
			step(1);
		end
		trig = 16'h0020;
		for (i = 0; i < 4; i++) begin
			n += int'(mem_rd);
			step(1);
		end
		chk_bit(n != 0, 1'h1);
		wait_idle();
		chk_words(22'h0000C0, 4);
		trig = 16'h0000;
	endtask

	// Priority interrupt held active throughout: peek must ignore it
	task automatic t_peek;
		int i;
		fetch = 1'h1;
		prio = 1'h1;
		irq = 1'h1;
		start(msa_pkg::MODE_PEEK, 22'h000100, 22'h000103);
		for (i = 0; i < 6; i++) begin
			chk_bit(mem_rd | stall, 1'h0);
			step(1);
		end
		chk_bit(scan_run, 1'h1);
		fetch = 1'h0;
		step(1);
		chk_bit(mem_rd, 1'h1);
		for (i = 0; i < 40 && busy !== 1'h0; i++) begin
			chk_bit(stall, 1'h0);
			step(1);
		end
		wait_idle();
		chk_words(22'h000100, 4);
		irq = 1'h0;
		fetch = 1'h1;
	endtask

	task automatic t_halt;
		logic [21:0] a;
		start(msa_pkg::MODE_BURST, 22'h000020, 22'h00002F);
		step(2);
		halt = 1'h1;
		step(1);
		chk_bit(mem_rd, 1'h0);
		a = low_addr;
		step(4);
		chk_val(low_addr, a);
		chk_bit(mem_rd | stall, 1'h0);
		chk_bit(done, 1'h0);
		halt = 1'h0;
		wait_idle();
		chk_words(22'h000020, 16);
	endtask

	// Halt already up when the burst is started: nothing moves until exit
	task automatic t_halt_start;
		int i;
		halt = 1'h1;
		start(msa_pkg::MODE_BURST, 22'h000030, 22'h000033);
		for (i = 0; i < 4; i++) begin
			chk_bit(mem_rd | stall, 1'h0);
			step(1);
		end
		chk_val(low_addr, 22'h000030);
		halt = 1'h0;
		step(2);
		chk_bit(stall, 1'h1);
		wait_idle();
		chk_words(22'h000030, 4);
	endtask

	task automatic t_abort;
		hold = 1'h1;
		start(msa_pkg::MODE_BURST, 22'h000200, 22'h0002FF);
		step(3);
		crc_go = 1'h0;
		step(1);
		chk_bit(scan_run, 1'h0);
		chk_bit(invalid, 1'h1);
		step(1);
		chk_bit(stall | busy | crc_valid | done, 1'h0);
		crc_go = 1'h1;
		hold = 1'h0;
	endtask

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	initial begin
		{rst_n, prio, run_set, run_clr, done_clr, irq, halt, hold} = 8'h00;
		{scan_en, crc_en, crc_go, fetch} = 4'hF;
		mode = 2'h0;
		tsel = 4'h0;
		trig = 16'h0000;
		sa = 22'h000000;
		ea = 22'h000000;
		bad_count = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		#5;
		rst_n = 1'h1;
		t_reset();
		t_burst();
		t_conc();
		t_irq(msa_pkg::MODE_CONCURRENT, 1'h1);
		t_irq(msa_pkg::MODE_CONCURRENT, 1'h0);
		t_irq(msa_pkg::MODE_BURST, 1'h1);
		t_irq(msa_pkg::MODE_BURST, 1'h0);
		t_trig();
		t_peek();
		t_halt();
		t_halt_start();
		t_abort();
		finish_test();
	end
endmodule
